// File: wcr_cnt_if.sv
// Purpose: carrier between the control logic and one watchdog counter
// Assumes: all signals on the system clock
// Notes:   hit is a one-cycle pulse from a flip-flop
`timescale 1ns/10ps
interface wcr_cnt_if #(parameter int W = 16);
    logic tick;            // one-cycle count enable
    logic enable;          // counter enabled
    logic clear;           // service: restart from zero
    logic clr_on_match;    // mode: wrap to zero on match
    logic [W-1:0] match;   // match value
    logic [W-1:0] count;   // current count
    logic hit;             // match event pulse
    modport ctl (output tick, enable, clear, clr_on_match, match, input count, hit);
    modport cnt (input tick, enable, clear, clr_on_match, match, output count, hit);
endinterface

// File: wcr_counter.sv
// Purpose: one watchdog counter with match event
// Assumes: tick is a one-cycle enable from a slow clock edge
// Notes:   service clear wins over counting
`timescale 1ns/10ps
module wcr_counter #(
    parameter int W = 16
) (
    input wire logic clk_in,           // system clock
    input wire logic rst_n_in,         // synchronous reset, active low
    wcr_cnt_if.cnt bus                 // control and status carrier
);
    logic [W-1:0] count_r;             // running count
    logic [W-1:0] count_nxt;           // next count
    logic hit_r;                       // match pulse
    wire at_match = (count_r == bus.match);
    wire step = bus.tick && bus.enable;

    // next count: clear, wrap on match, or increment
    assign count_nxt = bus.clear ? '0 :
                       (step && at_match && bus.clr_on_match) ? '0 :
                       step ? count_r + 1'b1 : count_r;

    // ****************************************************
    // count and match registers
    // ****************************************************
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            count_r <= '0;
            hit_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            hit_r <= step && at_match && !bus.clear;
        end
    end
    assign bus.count = count_r;
    assign bus.hit = hit_r;
endmodule

// File: wcr_fw_model.sv
// Purpose: firmware servicing and external reset source beside the block
// Assumes: commands from the bench change just after the rising clock edge
// Notes:   reset pin idles high as through a pull-up
`timescale 1ns/10ps
module wcr_fw_model (
    input wire logic clk_in,         // system clock
    input wire logic pin_low_in,     // command: pull the reset pin low
    input wire logic service_en_in,  // command: keep servicing the single watchdog
    output logic ext_rst_n_out,      // external reset pin level
    output logic swd_service_out     // one-cycle service pulse
);
    logic [3:0] gap_r; // cycles since last service
    // pin low only while commanded, pull-up level otherwise
    assign ext_rst_n_out = pin_low_in ? 1'b0 : 1'b1;
    initial gap_r = 4'h0;
    initial swd_service_out = 1'b0;
    // service once every 16 cycles, well inside the timeout
    always @(posedge clk_in) begin
        gap_r <= #1 gap_r + 4'h1;
        swd_service_out <= #1 service_en_in && (gap_r == 4'hf);
    end
endmodule

// File: wcr_pkg.sv
// What this block does
// - single watchdog: one free-running 16-bit counter
// - multi watchdog: two 16-bit, one 32-bit counter
// - every 16-bit counter can request device reset
// - every counter interrupts on match value
// - single watchdog ticks only from low-speed oscillator
// - single watchdog wakes in deep sleep and hibernate
// - multi watchdogs: selectable clock, silent in hibernate
// - unserviced enabled watchdog resets the device if its reset enable is set
// - power-up reset holds device until supply ready
// - brown-out requests device reset
// - external reset pin is active low
// - software request performs full device reset
// - protection fault gives interrupt or reset
// - hibernate freezes; any wakeup resets device
// - power-up, brown-out and pin resets act asynchronously, no clock needed
// - reset cause kept in register surviving reset
//
// Purpose: shared constants and types of the watchdog and reset control block
// Assumes: 100 MHz system clock
// Notes:   no software-visible registers; all controls are ports
package wcr_pkg;
    // ****************************************************
    // timing
    // ****************************************************
    localparam int CLK_PERIOD_NS = 10;             // system clock period
    localparam int RST_HOLD_NS = 1000;             // least width of an internal reset
    localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_W = 8;                     // width of the hold counter

    // ****************************************************
    // counter sizes
    // ****************************************************
    localparam int CNT16_W = 16;                   // short watchdog counters
    localparam int CNT32_W = 32;                   // long counter of a multi watchdog
    localparam int MCW_NUM = 2;                    // number of multi watchdogs
    localparam int MCW16_NUM = 2 * MCW_NUM;        // 16-bit counters across multi watchdogs

    // ****************************************************
    // reset cause bit positions
    // ****************************************************
    localparam int CAUSE_W = 8;                    // width of the cause register
    localparam int CAUSE_SWD = 0;                  // single watchdog
    localparam int CAUSE_MCW = 1;                  // a multi watchdog
    localparam int CAUSE_SW = 2;                   // software request
    localparam int CAUSE_PROT = 3;                 // protection fault
    localparam int CAUSE_HIB = 4;                  // hibernate wakeup
    localparam int CAUSE_BROWN = 5;                // brown-out
    localparam int CAUSE_EXT = 6;                  // external pin
    localparam logic [7:0] CAUSE_RST = 8'h00;      // value after power-up

    // ****************************************************
    // system mode one-hot positions
    // ****************************************************
    localparam int MODE_FULL = 0;                  // full_speed_system_mode
    localparam int MODE_RED = 1;                   // reduced_speed_system_mode
    localparam int MODE_DSLP = 2;                  // deep sleep
    localparam int MODE_HIB = 3;                   // hibernate

    // reset stretcher states
    typedef enum logic [1:0] {
        WCR_IDLE = 2'b01,
        WCR_HOLD = 2'b10
    } wcr_rst_state_t;
endpackage

// File: wcr_sync.sv
// Purpose: two-stage synchroniser for asynchronous levels
// Assumes: inputs slow compared to clk_in
// Notes:   first stage feeds only the second
`timescale 1ns/10ps
module wcr_sync #(
    parameter int W = 1
) (
    input wire logic clk_in,           // system clock
    input wire logic [W-1:0] d_in,     // asynchronous levels
    input wire logic [W-1:0] rst_val_in, // constant reset level (tie-off)
    input wire logic rst_n_in,         // synchronous reset, active low
    output logic [W-1:0] q_out         // synchronised levels
);
    logic [W-1:0] meta_r;              // first stage
    logic [W-1:0] q_r;                 // second stage

    // ****************************************************
    // two flip-flops in series
    // ****************************************************
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            meta_r <= rst_val_in;
            q_r <= rst_val_in;
        end else begin
            meta_r <= d_in;
            q_r <= meta_r;
        end
    end
    assign q_out = q_r;
endmodule

// File: wcr_top.sv
// Purpose: watchdogs and reset merge with retained reset cause
// Assumes: slow clocks arrive as pins and are sampled on clk_in
// Notes:   dev_rst_n_out is combinational so pin sources act without a clock
`timescale 1ns/10ps
module wcr_top (
    input wire logic clk_in,                 // 100 MHz system clock
    input wire logic rst_n_in,               // synchronous reset, active low
    input wire logic por_in,                 // power-up detector, high while ramping
    input wire logic brownout_in,            // brownout_reset detector, high on low supply
    input wire logic ext_rst_n_in,           // external_reset_pin, active low
    input wire logic lso_clk_in,             // low_speed_internal_osc
    input wire logic xtal_clk_in,            // watch_crystal_osc
    input wire logic slow_sel_in,            // low_frequency_clock source: 1 crystal
    input wire logic [3:0] sys_mode_in,      // one-hot system mode
    input wire logic sw_reset_req_in,        // software reset pulse
    input wire logic prot_fault_in,          // protection fault pulse
    input wire logic prot_rst_sel_in,        // fault action: 1 reset, 0 interrupt
    input wire logic hib_wake_in,            // asynchronous hibernate wake source
    input wire logic swd_enable_in,          // single watchdog enable
    input wire logic swd_service_in,         // single watchdog service pulse
    input wire logic swd_rst_en_in,          // single watchdog may reset
    input wire logic [15:0] swd_match_in,    // single watchdog match
    input wire logic [5:0] mcw_enable_in,    // multi counters enable
    input wire logic [5:0] mcw_service_in,   // multi counters service pulses
    input wire logic [5:0] mcw_wrap_in,      // multi counters wrap on match
    input wire logic [3:0] mcw_rst_en_in,    // 16-bit multi counters may reset
    input wire logic [63:0] mcw_match16_in,  // 16-bit matches, 16 bits each
    input wire logic [63:0] mcw_match32_in,  // 32-bit matches, 32 bits each
    input wire logic [7:0] cause_clr_in,     // write-one-to-clear cause pulse
    output logic dev_rst_n_out,              // device reset, active low
    output logic swd_irq_out,                // single watchdog interrupt pulse
    output logic [5:0] mcw_irq_out,          // multi counter interrupt pulses
    output logic prot_irq_out,               // protection fault interrupt pulse
    output logic wakeup_out,                 // wakeup pulse in low-power modes
    output logic hib_freeze_out,             // freeze device and I/O state
    output logic [7:0] reset_cause_out,      // retained reset cause
    output logic [15:0] swd_count_out        // single watchdog count
);
    // ****************************************************
    // input synchronisers
    // ****************************************************
    logic [5:0] pin_s;                       // synchronised pins
    logic lso_d_r;                           // delayed oscillator samples
    logic lfc_d_r;

    wcr_sync #(.W(6)) u_sync (
        .clk_in(clk_in),
        .d_in({hib_wake_in, ext_rst_n_in, brownout_in, por_in, xtal_clk_in, lso_clk_in}),
        .rst_val_in(6'h10),
        .rst_n_in(rst_n_in),
        .q_out(pin_s)
    );

    wire lso_s = pin_s[0];
    wire lfc_s = slow_sel_in ? pin_s[1] : pin_s[0];
    wire por_s = pin_s[2];
    wire brown_s = pin_s[3];
    wire ext_n_s = pin_s[4];
    wire wake_s = pin_s[5];

    // ****************************************************
    // slow clock edges become tick enables
    // ****************************************************
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            lso_d_r <= 1'b0;
            lfc_d_r <= 1'b0;
        end else begin
            lso_d_r <= lso_s;
            lfc_d_r <= lfc_s;
        end
    end

    wire hib = sys_mode_in[wcr_pkg::MODE_HIB];
    wire low_pwr = hib || sys_mode_in[wcr_pkg::MODE_DSLP];
    wire swd_tick = lso_s && !lso_d_r;
    wire mcw_tick = lfc_s && !lfc_d_r && !hib;

    // ****************************************************
    // counters
    // ****************************************************
    logic [4:0] hit16;                       // 0: single, 1..4: multi
    logic [1:0] hit32;                       // long counters
    logic [15:0] swd_count;                  // single watchdog count

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_c16
            wcr_cnt_if #(.W(wcr_pkg::CNT16_W)) cif ();
            if (gi == 0) begin : g_swd
                assign cif.tick = swd_tick;
                assign cif.enable = swd_enable_in;
                assign cif.clear = swd_service_in;
                assign cif.clr_on_match = 1'b0;
                assign cif.match = swd_match_in;
                assign swd_count = cif.count;
            end else begin : g_mcw
                assign cif.tick = mcw_tick;
                assign cif.enable = mcw_enable_in[3*((gi-1)/2) + (gi-1)%2];
                assign cif.clear = mcw_service_in[3*((gi-1)/2) + (gi-1)%2];
                assign cif.clr_on_match = mcw_wrap_in[3*((gi-1)/2) + (gi-1)%2];
                assign cif.match = mcw_match16_in[16*(gi-1) +: 16];
            end
            assign hit16[gi] = cif.hit;
            wcr_counter #(.W(wcr_pkg::CNT16_W)) u_cnt (
                .clk_in(clk_in),
                .rst_n_in(rst_n_in),
                .bus(cif.cnt)
            );
        end
        for (gi = 0; gi < wcr_pkg::MCW_NUM; gi++) begin : g_c32
            wcr_cnt_if #(.W(wcr_pkg::CNT32_W)) cif ();
            assign cif.tick = mcw_tick;
            assign cif.enable = mcw_enable_in[3*gi+2];
            assign cif.clear = mcw_service_in[3*gi+2];
            assign cif.clr_on_match = mcw_wrap_in[3*gi+2];
            assign cif.match = mcw_match32_in[32*gi +: 32];
            assign hit32[gi] = cif.hit;
            wcr_counter #(.W(wcr_pkg::CNT32_W)) u_cnt (
                .clk_in(clk_in),
                .rst_n_in(rst_n_in),
                .bus(cif.cnt)
            );
        end
    endgenerate

    // ****************************************************
    // reset requests and cause sources
    // ****************************************************
    wire swd_rst = hit16[0] && swd_rst_en_in;
    wire mcw_rst = |(hit16[4:1] & mcw_rst_en_in);
    wire prot_rst = prot_fault_in && prot_rst_sel_in;
    wire hib_rst = hib && (wake_s || hit16[0]);
    wire int_req = swd_rst || mcw_rst || sw_reset_req_in || prot_rst || hib_rst;

    logic [7:0] cause_set;                   // sources firing this cycle
    assign cause_set = {1'b0, !ext_n_s, brown_s, hib_rst, prot_rst,
                        sw_reset_req_in, mcw_rst, swd_rst};

    // ****************************************************
    // internal reset stretcher, cleared only at power-up
    // ****************************************************
    wcr_pkg::wcr_rst_state_t st_r;           // stretcher state
    logic [wcr_pkg::HOLD_W-1:0] hold_r;      // remaining hold cycles
    wire rst_hold = (st_r == wcr_pkg::WCR_HOLD);

    always_ff @(posedge clk_in) begin
        if (por_s) begin
            st_r <= wcr_pkg::WCR_IDLE;
            hold_r <= '0;
        end else begin
            case (st_r)
                wcr_pkg::WCR_IDLE: begin
                    if (int_req) begin
                        st_r <= wcr_pkg::WCR_HOLD;
                        hold_r <= wcr_pkg::HOLD_W'(wcr_pkg::RST_HOLD_CYC - 1);
                    end
                end
                wcr_pkg::WCR_HOLD: begin
                    if (hold_r == '0) begin
                        st_r <= wcr_pkg::WCR_IDLE;
                    end else begin
                        hold_r <= hold_r - 1'b1;
                    end
                end
                default: begin
                    st_r <= wcr_pkg::WCR_IDLE;
                end
            endcase
        end
    end

    // pin sources pass straight through, no clock edge needed
    assign dev_rst_n_out = !(por_in || brownout_in || !ext_rst_n_in || rst_hold);

    // ****************************************************
    // retained cause register, cleared by power-up or cause_clr_in
    // ****************************************************
    logic [7:0] cause_r;                     // retained cause bits

    always_ff @(posedge clk_in) begin
        if (por_s) begin
            cause_r <= wcr_pkg::CAUSE_RST;
        end else begin
            cause_r <= cause_set | (cause_r & ~cause_clr_in);
        end
    end
    assign reset_cause_out = cause_r;

    // ****************************************************
    // interrupts and wakeup
    // ****************************************************
    logic swd_irq_r;
    logic [5:0] mcw_irq_r;
    logic prot_irq_r;
    logic wake_r;
    logic [5:0] mcw_hits;
    assign mcw_hits = {hit32[1], hit16[4:3], hit32[0], hit16[2:1]};

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            swd_irq_r <= 1'b0;
            mcw_irq_r <= '0;
            prot_irq_r <= 1'b0;
            wake_r <= 1'b0;
        end else begin
            swd_irq_r <= hit16[0];
            mcw_irq_r <= mcw_hits;
            prot_irq_r <= prot_fault_in && !prot_rst_sel_in;
            wake_r <= low_pwr && (hit16[0] || |mcw_hits);
        end
    end
    assign swd_irq_out = swd_irq_r;
    assign mcw_irq_out = mcw_irq_r;
    assign prot_irq_out = prot_irq_r;
    assign wakeup_out = wake_r;
    assign hib_freeze_out = hib && !rst_hold;
    assign swd_count_out = swd_count;

    // ****************************************************
    // checks
    // ****************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in || por_s);

    chk_swd_reset_req: assert property (
        swd_rst && st_r == wcr_pkg::WCR_IDLE |=> rst_hold ##0 !dev_rst_n_out)
        else $error("watchdog match did not start reset");
    chk_irq_on_match: assert property (
        hit16[0] |=> swd_irq_out)
        else $error("match gave no interrupt");
    chk_mcw_hib_quiet: assert property (
        hib |-> ##2 mcw_irq_out == 6'h00)
        else $error("multi watchdog ticked in hibernate");
    chk_brown_reset: assert property (
        brownout_in |-> !dev_rst_n_out)
        else $error("brown-out did not reset");
    chk_ext_pin_reset: assert property (
        !ext_rst_n_in |-> !dev_rst_n_out)
        else $error("low pin did not reset");
    chk_sw_reset_len: assert property (
        sw_reset_req_in && st_r == wcr_pkg::WCR_IDLE |=> rst_hold [*8])
        else $error("software reset too short");
    chk_prot_route: assert property (
        prot_fault_in && !prot_rst_sel_in && !int_req && st_r == wcr_pkg::WCR_IDLE
        |=> prot_irq_out && !rst_hold)
        else $error("fault routed wrongly");
    chk_hib_wake_reset: assert property (
        hib && wake_s && st_r == wcr_pkg::WCR_IDLE |=> rst_hold ##1 !hib_freeze_out)
        else $error("hibernate wake did not reset");
    chk_cause_set_wins: assert property (
        cause_set[wcr_pkg::CAUSE_SW] && cause_clr_in[wcr_pkg::CAUSE_SW]
        |=> reset_cause_out[wcr_pkg::CAUSE_SW])
        else $error("cause set lost to clear");
    chk_service_clears: assert property (
        swd_service_in |=> swd_count_out == 16'h0000)
        else $error("service did not restart count");

    cov_swd_timeout: cover property (swd_rst ##1 rst_hold);
    cov_mcw_irq: cover property (|mcw_irq_out);
    cov_hib_wake: cover property (hib && wake_s ##1 rst_hold);
endmodule

// File: wcr_top_test.sv
// Purpose: self-checking bench of the watchdog and reset control block
// Assumes: inputs change 1 ns after the rising edge
// Notes:   slow clocks run free from time zero
`timescale 1ns/10ps
module wcr_top_test;
    logic clk_in, rst_n_in, por_in, brownout_in, ext_rst_n_in, lso_clk_in, xtal_clk_in, slow_sel_in;
    logic sw_reset_req_in, prot_fault_in, prot_rst_sel_in, hib_wake_in, swd_enable_in, swd_service_in;
    logic swd_rst_en_in, pin_low, svc_en, dev_rst_n_out, swd_irq_out, prot_irq_out, wakeup_out;
    logic hib_freeze_out;
    logic [3:0] sys_mode_in, mcw_rst_en_in;
    logic [5:0] mcw_enable_in, mcw_service_in, mcw_wrap_in, mcw_irq_out;
    logic [15:0] swd_match_in, swd_count_out;
    logic [63:0] mcw_match16_in, mcw_match32_in;
    logic [7:0] cause_clr_in, reset_cause_out;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int seed;
    // ****************************************************
    // clocks, design and partner
    // ****************************************************
    initial begin clk_in = 0; forever #5 clk_in = ~clk_in; end
    initial begin lso_clk_in = 0; forever #40 lso_clk_in = ~lso_clk_in; end
    initial begin xtal_clk_in = 0; forever #55 xtal_clk_in = ~xtal_clk_in; end
    wcr_top u_dut (.clk_in, .rst_n_in, .por_in, .brownout_in, .ext_rst_n_in, .lso_clk_in, .xtal_clk_in,
        .slow_sel_in, .sys_mode_in, .sw_reset_req_in, .prot_fault_in, .prot_rst_sel_in, .hib_wake_in,
        .swd_enable_in, .swd_service_in, .swd_rst_en_in, .swd_match_in, .mcw_enable_in, .mcw_service_in,
        .mcw_wrap_in, .mcw_rst_en_in, .mcw_match16_in, .mcw_match32_in, .cause_clr_in, .dev_rst_n_out,
        .swd_irq_out, .mcw_irq_out, .prot_irq_out, .wakeup_out, .hib_freeze_out, .reset_cause_out,
        .swd_count_out);
    wcr_fw_model u_fw (.clk_in(clk_in), .pin_low_in(pin_low), .service_en_in(svc_en),
        .ext_rst_n_out(ext_rst_n_in), .swd_service_out(swd_service_in));
    // ****************************************************
    // helper tasks
    // ****************************************************
    task cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // wait for device reset to go low, bounded
    task wait_low(input int lim);
        for (int k = 0; k < lim && dev_rst_n_out !== 1'b0; k++) cyc(1);
    endtask
    // let the stretcher finish, then check and clear the cause
    task done_cause(input logic [7:0] exp);
        for (int k = 0; k < 300 && dev_rst_n_out !== 1'b1; k++) cyc(1);
        cyc(2);
        chk("cause", {24'h0, exp}, {24'h0, reset_cause_out});
        cause_clr_in = 8'hff;
        cyc(1);
        cause_clr_in = 8'h00;
        cyc(1);
        chk("cleared", 32'h0, {24'h0, reset_cause_out});
    endtask
    task end_of_test;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // hang guard
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            end_of_test();
        end
    end
    // ****************************************************
    // main sequence
    // ****************************************************
    initial begin
        int m;
        int idx;
        logic seen;
        logic [15:0] c0;
        seed = 32'h2a0d78f2;
        {rst_n_in, brownout_in, pin_low, svc_en, slow_sel_in, sw_reset_req_in, prot_fault_in} = '0;
        {prot_rst_sel_in, hib_wake_in, swd_enable_in, swd_rst_en_in} = '0;
        por_in = 1;
        sys_mode_in = 4'h1;
        {swd_match_in, mcw_enable_in, mcw_service_in, mcw_wrap_in, mcw_rst_en_in} = '0;
        {mcw_match16_in, mcw_match32_in, cause_clr_in} = '0;
        cyc(1);
        chk("por hold", 32'h0, {31'h0, dev_rst_n_out});
        cyc(11);
        // power-up outlasts reset so its synchronised copy clears cause and stretcher
        rst_n_in = 1;
        cyc(3);
        por_in = 0;
        cyc(4);
        chk("cause rst", {24'h0, wcr_pkg::CAUSE_RST}, {24'h0, reset_cause_out});
        // power-up detector acts between edges
        por_in = 1;
        #2 chk("por async", 32'h0, {31'h0, dev_rst_n_out});
        cyc(1);
        por_in = 0;
        cyc(4);
        // software request: stretched reset of fixed length
        sw_reset_req_in = 1;
        cause_clr_in = 8'hff;
        cyc(1);
        sw_reset_req_in = 0;
        cause_clr_in = 8'h00;
        m = 0;
        while (dev_rst_n_out === 1'b0 && m < 300) begin m++; cyc(1); end
        chk("sw hold", wcr_pkg::RST_HOLD_CYC, m);
        done_cause(8'h04);
        // brown-out level
        brownout_in = 1;
        cyc(3);
        chk("brownout", 32'h0, {31'h0, dev_rst_n_out});
        brownout_in = 0;
        done_cause(8'h20);
        // external pin, no clock edge needed
        pin_low = 1;
        #2 chk("ext async", 32'h0, {31'h0, dev_rst_n_out});
        cyc(3);
        pin_low = 0;
        done_cause(8'h40);
        // protection fault: interrupt first, then reset
        prot_fault_in = 1;
        cyc(1);
        prot_fault_in = 0;
        seen = 0;
        repeat (4) begin seen |= prot_irq_out; cyc(1); end
        chk("prot irq", 32'h1, {31'h0, seen});
        chk("prot norst", 32'h1, {31'h0, dev_rst_n_out});
        prot_rst_sel_in = 1;
        prot_fault_in = 1;
        cyc(1);
        prot_fault_in = 0;
        wait_low(4);
        chk("prot rst", 32'h0, {31'h0, dev_rst_n_out});
        done_cause(8'h08);
        // single watchdog counts one per slow tick
        swd_enable_in = 1;
        swd_match_in = 16'hffff;
        cyc(2);
        c0 = swd_count_out;
        for (int k = 0; k < 20 && swd_count_out === c0; k++) cyc(1);
        chk("count step", {16'h0, c0 + 16'h1}, {16'h0, swd_count_out});
        // deep sleep: match gives interrupt and wakeup
        svc_en = 1;
        cyc(20);
        svc_en = 0;
        sys_mode_in = 4'h4;
        swd_match_in = 16'h0004 + 16'($random(seed) & 7);
        {m, seen} = '0;
        for (int k = 0; k < 200; k++) begin seen |= swd_irq_out; m |= wakeup_out; cyc(1); end
        chk("swd irq", 32'h1, {31'h0, seen});
        chk("swd wake", 32'h1, m);
        // serviced watchdog stays quiet, neglected one resets
        sys_mode_in = 4'h1;
        swd_rst_en_in = 1;
        swd_match_in = 16'h0004 + 16'($random(seed) & 15);
        svc_en = 1;
        seen = 1;
        for (int k = 0; k < 400; k++) begin seen &= dev_rst_n_out; cyc(1); end
        chk("serviced", 32'h1, {31'h0, seen});
        svc_en = 0;
        wait_low(800);
        chk("swd rst", 32'h0, {31'h0, dev_rst_n_out});
        {swd_enable_in, swd_rst_en_in} = '0;
        done_cause(8'h01);
        // every multi counter matches, both slow clock sources
        for (int j = 0; j < 6; j++) begin
            slow_sel_in = j[0];
            mcw_match16_in = {4{16'h0002 + 16'($random(seed) & 3)}};
            mcw_match32_in = {2{32'h2 + 32'($random(seed) & 3)}};
            mcw_service_in = 6'h3f;
            cyc(1);
            mcw_service_in = 6'h00;
            mcw_enable_in = 6'h01 << j;
            seen = 0;
            for (int k = 0; k < 300 && !seen; k++) begin seen = mcw_irq_out[j]; cyc(1); end
            chk("mcw irq", 32'h1, {31'h0, seen});
        end
        // each 16-bit multi counter can reset
        for (int j = 0; j < 4; j++) begin
            idx = (j / 2) * 3 + j % 2;
            mcw_service_in = 6'h3f;
            cyc(1);
            mcw_service_in = 6'h00;
            mcw_enable_in = 6'h01 << idx;
            mcw_rst_en_in = 4'h1 << j;
            wait_low(300);
            chk("mcw rst", 32'h0, {31'h0, dev_rst_n_out});
            {mcw_enable_in, mcw_rst_en_in} = '0;
            done_cause(8'h02);
        end
        // hibernate: frozen, multi counter 0 silent, wake resets
        sys_mode_in = 4'h8;
        mcw_match16_in = {4{16'h0001}};
        mcw_enable_in = 6'h01;
        cyc(2);
        chk("freeze", 32'h1, {31'h0, hib_freeze_out});
        seen = 0;
        for (int k = 0; k < 200; k++) begin seen |= mcw_irq_out[0]; cyc(1); end
        chk("hib silent", 32'h0, {31'h0, seen});
        hib_wake_in = 1;
        wait_low(20);
        chk("hib wake", 32'h0, {31'h0, dev_rst_n_out});
        {hib_wake_in, mcw_enable_in} = '0;
        sys_mode_in = 4'h1;
        done_cause(8'h10);
        end_of_test();
    end
endmodule
